// *** inc/spmb_pkg.sv ***
// Package: registers, fields and timing counts
// ----------------------------------------------------------------------------
// Overview of operation
// [RULE1] Mode 0: data on rx pin, clock on tx
// [RULE2] Mode 0 clock: system clock /12 or /2
// [RULE3] Mode 0 shift clock always made here
// [RULE4] Mode 0 shifts LSB first, one per clock
// [RULE5] Mode 0 buffer write sends 8 bits, flags
// [RULE6] Mode 0 receives while enabled, flag clear
// [RULE7] Mode 1 frame: start, 8 data, stop
// [RULE8] Mode 1 baud from timer ticks, doubled
// [RULE9] Mode 1 send; done flag at stop
// [RULE10] Mode 1 receive starts on falling edge
// [RULE11] Mode 1 accept: flag clear, filter passes
// [RULE12] Accepted: load data, ninth, set flag
// [RULE13] Modes 2/3 frame adds ninth bit
// [RULE14] Mode 2 baud: clock /64 or /32
// [RULE15] Modes 2/3 send data, ninth, stop
// [RULE16] Modes 2/3 receive on start falling edge
// [RULE17] Modes 2/3 accept rule, then load
// [RULE18] Mode 3 is mode 2 with timer ticks
// [RULE19] Port 0 picks timer 1 or 3
// [RULE20] Port 1 uses timer 3 ticks only
// [RULE21] Timer 1 baud scaled by double bit/32
// [RULE22] Timer 3 baud: port 0 or /16
// [RULE23] Software keeps baud timer interrupt off
// [RULE24] Buffer write to transmit, read receive
// ----------------------------------------------------------------------------
package spmb_pkg;
    // ------------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BUF = 8'h04;
    localparam logic [7:0] OFF_PWR = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0C;
    localparam logic [7:0] OFF_T3CTL = 8'hC4;
    // ------------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------------
    localparam int PWR_DOUBLE_BIT = 7;
    localparam int T3_DOUBLE1_BIT = 7;
    localparam int T3_BAUD_SEL_BIT = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] T3CTL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    // ------------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------------
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] MID_START = 4'h7;
    localparam logic [3:0] SHIFT_HALF_SLOW = 4'h6;
    localparam logic [3:0] SHIFT_HALF_FAST = 4'h1;
    localparam logic [3:0] FIXED_DIV_SLOW = 4'h4;
    localparam logic [3:0] FIXED_DIV_FAST = 4'h2;
    localparam logic [3:0] SHIFT_BITS = 4'h8;
    localparam logic [3:0] FRAME_SHORT = 4'hA;
    localparam logic [3:0] FRAME_LONG = 4'hB;
    localparam logic [3:0] RX_SHORT = 4'h9;
    localparam logic [3:0] RX_LONG = 4'hA;

    typedef enum logic [1:0] {
        MODE_SHIFT,
        MODE_ASYNC8,
        MODE_FIXED9,
        MODE_TIMER9
    } spmb_mode_t;

    typedef struct packed {
        spmb_mode_t mode;
        logic addr_filter_fast_shift;
        logic rx_enable;
        logic transmit_ninth_bit;
        logic received_ninth_bit;
        logic transmit_done_flag;
        logic receive_done_flag;
    } spmb_ctrl_t;
endpackage : spmb_pkg

// *** rtl/spmb_tick_div.sv ***
// Module: divider giving a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module spmb_tick_div #(
    parameter int W = 4
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic clr, // Restart the count
    input wire logic [W-1:0] period, // Cycles per tick
    output logic tick // One-cycle tick
);
    logic [W-1:0] cnt_reg;
    logic last;

    generate
        if (W < 2) begin : g_chk
            $error("spmb_tick_div: W must be at least 2");
        end
    endgenerate

    assign last = (cnt_reg >= period - {{(W-1){1'b0}}, 1'b1});
    assign tick = ce && !clr && last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (ce) begin
            if (clr || last) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule : spmb_tick_div
`default_nettype wire

// *** rtl/spmb_serial_port.sv ***
// Module: four-mode serial port engine with APB register access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spmb_serial_port #(
    parameter int PORT_INDEX = 0
) (
    input wire logic pclk, // System clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic timer1_tick, // Timer 1 overflow pulse
    input wire logic timer3_tick, // Timer 3 overflow pulse
    input wire logic rxd_in, // Receive pin level
    output logic rxd_out, // Receive pin drive value, mode 0
    output logic rxd_oe, // Receive pin drive enable
    output logic txd_out // Transmit pin / shift clock
);
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_ASYNC,
        SH_TX,
        SH_RX
    } spmb_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_BITS
    } spmb_rx_state_t;

    generate
        if (PORT_INDEX < 0 || PORT_INDEX > 1) begin : g_chk
            $error("spmb_serial_port: PORT_INDEX must be 0 or 1");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    spmb_pkg::spmb_ctrl_t ctrl_reg;
    logic [7:0] tx_data_reg;
    logic [7:0] rx_buf_reg;
    logic [7:0] pwr_reg;
    logic [7:0] t3ctl_reg;
    logic [15:0] addr_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] rdata_next;
    logic hit;
    logic wr_ctrl, wr_buf;
    logic set_ti, rx_load, rx_load_ninth;
    logic [7:0] rx_load_data;
    logic rx_ninth_val;
    spmb_pkg::spmb_mode_t mode;
    logic double_rate;

    assign mode = ctrl_reg.mode;
    assign pready = ce;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_comb begin
        hit = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            spmb_pkg::OFF_CTRL: rdata_next[7:0] = ctrl_reg;
            spmb_pkg::OFF_BUF: rdata_next[7:0] = rx_buf_reg; // RULE24
            spmb_pkg::OFF_PWR: rdata_next[7:0] = pwr_reg;
            spmb_pkg::OFF_ADDR: rdata_next[15:0] = addr_reg;
            spmb_pkg::OFF_T3CTL: rdata_next[7:0] = t3ctl_reg;
            default: hit = 1'b0;
        endcase
    end

    // Read data and error latched at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (ce && psel && !penable) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr_reg <= !hit;
        end
    end

    logic wr_any;
    assign wr_any = ce && psel && penable && pwrite;
    assign wr_ctrl = wr_any && (paddr == spmb_pkg::OFF_CTRL);
    assign wr_buf = wr_any && (paddr == spmb_pkg::OFF_BUF);

    // Hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= spmb_pkg::CTRL_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (set_ti) begin
                ctrl_reg.transmit_done_flag <= 1'b1;
            end
            if (rx_load) begin
                ctrl_reg.receive_done_flag <= 1'b1; // RULE12
            end
            if (rx_load && rx_load_ninth) begin
                ctrl_reg.received_ninth_bit <= rx_ninth_val; // RULE12
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_reg <= spmb_pkg::BUF_RST;
            pwr_reg <= spmb_pkg::PWR_RST;
            t3ctl_reg <= spmb_pkg::T3CTL_RST;
            addr_reg <= spmb_pkg::ADDR_RST;
        end else if (ce && wr_any) begin
            case (paddr)
                spmb_pkg::OFF_BUF: tx_data_reg <= pwdata[7:0]; // RULE24
                spmb_pkg::OFF_PWR: pwr_reg <= pwdata[7:0];
                spmb_pkg::OFF_ADDR: addr_reg <= pwdata[15:0];
                spmb_pkg::OFF_T3CTL: t3ctl_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_reg <= spmb_pkg::BUF_RST;
        end else if (ce && rx_load) begin
            rx_buf_reg <= rx_load_data; // RULE12
        end
    end

    // ------------------------------------------------------------------------
    // Baud sources
    // ------------------------------------------------------------------------
    logic src_tick, half_reg, timer_s16, fixed_s16, s16;
    logic half_tick;
    spmb_tx_state_t tx_state;
    logic [3:0] fixed_period, half_period;

    // Port 1 double bit sits in timer 3 control
    assign double_rate = (PORT_INDEX == 1) ?
        t3ctl_reg[spmb_pkg::T3_DOUBLE1_BIT] :
        pwr_reg[spmb_pkg::PWR_DOUBLE_BIT];

    assign src_tick = (PORT_INDEX == 1) ? timer3_tick : // RULE20
        (t3ctl_reg[spmb_pkg::T3_BAUD_SEL_BIT] ?
        timer3_tick : timer1_tick); // RULE19

    // Ticks divided by 16 per bit, by 32 unless doubled (port 1: 16 fixed)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_reg <= 1'b0;
        end else if (ce && src_tick) begin
            half_reg <= !half_reg;
        end
    end
    assign timer_s16 = ce && src_tick &&
        ((PORT_INDEX == 1) || double_rate || half_reg); // RULE8 RULE21 RULE22

    assign fixed_period = double_rate ? spmb_pkg::FIXED_DIV_FAST :
        spmb_pkg::FIXED_DIV_SLOW; // RULE14

    spmb_tick_div #(.W(4)) u_fixed_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clr(wr_buf && tx_state == TX_IDLE),
        .period(fixed_period),
        .tick(fixed_s16)
    );

    assign s16 = (mode == spmb_pkg::MODE_FIXED9) ? fixed_s16 :
        timer_s16; // RULE18

    // Half period of the mode 0 shift clock
    assign half_period = ctrl_reg.addr_filter_fast_shift ?
        spmb_pkg::SHIFT_HALF_FAST : spmb_pkg::SHIFT_HALF_SLOW; // RULE2

    spmb_tick_div #(.W(4)) u_shift_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clr(tx_state == TX_IDLE),
        .period(half_period),
        .tick(half_tick)
    );

    // ------------------------------------------------------------------------
    // Transmit and mode 0 shift engine
    // ------------------------------------------------------------------------
    logic [10:0] tx_sh_reg;
    logic [3:0] tx_bits_reg;
    logic [3:0] tx_phase_reg;
    logic tx_line_reg;
    logic rxd_out_reg, rxd_oe_reg;
    logic m0_rx_go;

    assign txd_out = tx_line_reg;
    assign rxd_out = rxd_out_reg;
    assign rxd_oe = rxd_oe_reg;
    // A write takes priority over receive
    assign m0_rx_go = (mode == spmb_pkg::MODE_SHIFT) && !wr_buf &&
        ctrl_reg.rx_enable && !ctrl_reg.receive_done_flag; // RULE6

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            tx_sh_reg <= 11'h7FF;
            tx_bits_reg <= 4'h0;
            tx_phase_reg <= 4'h0;
            tx_line_reg <= 1'b1;
            rxd_out_reg <= 1'b1;
            rxd_oe_reg <= 1'b0;
        end else if (ce) begin
            case (tx_state)
                TX_IDLE: begin
                    tx_line_reg <= 1'b1;
                    tx_phase_reg <= 4'h0;
                    if (wr_buf && mode != spmb_pkg::MODE_SHIFT) begin
                        tx_state <= TX_ASYNC;
                        tx_line_reg <= 1'b0; // RULE7 RULE13
                        tx_sh_reg <= {1'b1, (mode == spmb_pkg::MODE_ASYNC8) ?
                            1'b1 : ctrl_reg.transmit_ninth_bit,
                            pwdata[7:0], 1'b0}; // RULE9 RULE15
                        tx_bits_reg <= (mode == spmb_pkg::MODE_ASYNC8) ?
                            spmb_pkg::FRAME_SHORT : spmb_pkg::FRAME_LONG;
                    end else if (wr_buf) begin
                        tx_state <= SH_TX; // RULE5
                        tx_sh_reg <= {3'b111, pwdata[7:0]};
                        tx_bits_reg <= spmb_pkg::SHIFT_BITS;
                        rxd_out_reg <= pwdata[0];
                        rxd_oe_reg <= 1'b1; // RULE1
                    end else if (m0_rx_go) begin
                        tx_state <= SH_RX;
                        tx_bits_reg <= spmb_pkg::SHIFT_BITS;
                        rxd_oe_reg <= 1'b0;
                    end
                end
                TX_ASYNC: begin
                    if (s16) begin
                        tx_phase_reg <= tx_phase_reg + 4'h1;
                    end
                    if (s16 && tx_phase_reg == spmb_pkg::OVS_LAST) begin
                        if (tx_bits_reg == 4'h1) begin
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]}; // RULE7
                            tx_line_reg <= tx_sh_reg[1];
                            tx_bits_reg <= tx_bits_reg - 4'h1;
                        end
                    end
                end
                SH_TX, SH_RX: begin
                    if (half_tick) begin
                        tx_line_reg <= !tx_line_reg; // RULE3
                        if (tx_line_reg && tx_state == SH_TX) begin
                            rxd_out_reg <= tx_sh_reg[0]; // RULE4
                        end
                        if (!tx_line_reg) begin
                            // Rising edge: one bit per shift clock
                            if (tx_state == SH_RX) begin
                                tx_sh_reg[7:0] <= {rxd_in, tx_sh_reg[7:1]};
                            end else begin
                                tx_sh_reg[7:0] <= {1'b1, tx_sh_reg[7:1]};
                            end
                            tx_bits_reg <= tx_bits_reg - 4'h1;
                            if (tx_bits_reg == 4'h1) begin
                                tx_state <= TX_IDLE;
                                rxd_oe_reg <= 1'b0;
                                rxd_out_reg <= 1'b1;
                            end
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Done at stop bit start or last shift clock
    always_comb begin
        set_ti = 1'b0;
        if (ce && tx_state == TX_ASYNC && s16 &&
            tx_phase_reg == spmb_pkg::OVS_LAST && tx_bits_reg == 4'h2) begin
            set_ti = 1'b1; // RULE9 RULE15
        end
        if (ce && tx_state == SH_TX && half_tick && !tx_line_reg &&
            tx_bits_reg == 4'h1) begin
            set_ti = 1'b1; // RULE5
        end
    end

    // ------------------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------------------
    spmb_rx_state_t rx_state;
    logic rx_prev_reg;
    logic [9:0] rx_sh_reg;
    logic [3:0] rx_bits_reg;
    logic [3:0] rx_phase_reg;
    logic [9:0] rx_full;
    logic rx_last, rx_short, accept, addr_match;
    logic [7:0] rx_data;
    logic rx_ninth;

    assign rx_short = (mode == spmb_pkg::MODE_ASYNC8);
    assign rx_full = {rxd_in, rx_sh_reg[9:1]};
    assign rx_data = rx_short ? rx_full[8:1] : rx_full[7:0];
    // In mode 1 the stop bit stands in for the ninth bit
    assign rx_ninth = rx_short ? rx_full[9] : rx_full[8];
    assign addr_match = (rx_data == addr_reg[7:0]) ||
        (rx_data == addr_reg[15:8]);
    assign rx_last = ce && rx_state == RX_BITS && s16 &&
        rx_phase_reg == spmb_pkg::OVS_LAST && rx_bits_reg == 4'h1;
    assign accept = !ctrl_reg.receive_done_flag &&
        (!ctrl_reg.addr_filter_fast_shift ||
        (rx_ninth && addr_match)); // RULE11 RULE17

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_reg <= 1'b1;
        end else if (ce) begin
            rx_prev_reg <= rxd_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            rx_sh_reg <= 10'h000;
            rx_bits_reg <= 4'h0;
            rx_phase_reg <= 4'h0;
        end else if (ce) begin
            case (rx_state)
                RX_IDLE: begin
                    rx_phase_reg <= 4'h0;
                    if (mode != spmb_pkg::MODE_SHIFT &&
                        ctrl_reg.rx_enable && rx_prev_reg && !rxd_in) begin
                        rx_state <= RX_START; // RULE10 RULE16
                    end
                end
                RX_START: begin
                    if (s16) begin
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                        if (rx_phase_reg == spmb_pkg::MID_START) begin
                            // A glitch shorter than half a bit is dropped
                            rx_state <= rxd_in ? RX_IDLE : RX_BITS;
                            rx_phase_reg <= 4'h0;
                            rx_bits_reg <= rx_short ? spmb_pkg::RX_SHORT :
                                spmb_pkg::RX_LONG;
                        end
                    end
                end
                RX_BITS: begin
                    if (s16) begin
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                        if (rx_phase_reg == spmb_pkg::OVS_LAST) begin
                            rx_sh_reg <= rx_full; // RULE10
                            rx_bits_reg <= rx_bits_reg - 4'h1;
                            if (rx_bits_reg == 4'h1) begin
                                rx_state <= RX_IDLE; // RULE10 RULE16
                            end
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // One load path for all modes
    always_comb begin
        rx_load = 1'b0;
        rx_load_ninth = 1'b0;
        rx_load_data = rx_data;
        rx_ninth_val = rx_ninth;
        if (ce && tx_state == SH_RX && half_tick && !tx_line_reg &&
            tx_bits_reg == 4'h1) begin
            rx_load = 1'b1; // RULE6
            rx_load_data = {rxd_in, tx_sh_reg[7:1]};
        end else if (rx_last && accept) begin
            rx_load = 1'b1; // RULE12 RULE17
            rx_load_ninth = 1'b1;
        end
    end
endmodule : spmb_serial_port
`default_nettype wire

// *** test/spmb_serial_port_props.sv ***
// Checker: port-level properties of the serial port engine
`timescale 1ns/1ps
`default_nettype none
module spmb_serial_port_props (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic rxd_out, // Data pin value
    input wire logic rxd_oe, // Data pin enable
    input wire logic txd_out // Serial out or shift clock
);
    logic [1:0] mode_q;
    logic fast_q, dbl_q;
    logic [7:0] low_cnt;
    wire logic wr_acc = psel && penable && pwrite && ce;
    wire logic wr_buf = wr_acc && paddr == spmb_pkg::OFF_BUF;
    wire logic setup = psel && !penable && ce;
    // Mirror of pin timing settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            fast_q <= 1'b0;
            dbl_q <= 1'b0;
        end else if (wr_acc && paddr == spmb_pkg::OFF_CTRL) begin
            mode_q <= pwdata[7:6];
            fast_q <= pwdata[5];
        end else if (wr_acc && paddr == spmb_pkg::OFF_PWR) begin
            dbl_q <= pwdata[7];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= txd_out ? 8'h00 : low_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_low_half;
        !txd_out [*6] ##1 txd_out;
    endsequence
    a_ready_tracks_ce: assert property (pready == ce)
        else $error("ready not ce");
    a_err_unmapped: assert property (setup && paddr == 8'h10 |=> pslverr)
        else $error("unmapped not refused");
    a_err_mapped: assert property (
        setup && paddr == spmb_pkg::OFF_BUF |=> !pslverr)
        else $error("buffer address refused");
    a_m0_drive_start: assert property (wr_buf && mode_q == 2'h0
        |=> rxd_oe && rxd_out == $past(pwdata[0]))
        else $error("first bit not driven");
    a_async_start: assert property (
        wr_buf && mode_q != 2'h0 |=> !txd_out)
        else $error("start bit missing");
    a_oe_mode0_only: assert property (rxd_oe |-> mode_q == 2'h0)
        else $error("data pin driven off mode 0");
    a_shift_half: assert property (
        mode_q == 2'h0 && !fast_q && $fell(txd_out) |-> s_low_half)
        else $error("shift low phase wrong");
    a_m2_bit_len: assert property (mode_q == 2'h2 && $rose(txd_out)
        |-> low_cnt[4:0] == 5'h00 && (dbl_q || !low_cnt[5]))
        else $error("bit length wrong");
    a_release_idle: assert property ($fell(rxd_oe) |-> txd_out)
        else $error("clock not idle");
endmodule : spmb_serial_port_props
bind spmb_serial_port spmb_serial_port_props i_props (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .rxd_out, .rxd_oe, .txd_out);
`default_nettype wire

// *** test/spmb_far_end.sv ***
// Partner model: external serial device on the two serial pins
`timescale 1ns/1ps
`default_nettype none
module spmb_far_end (
    input wire logic pclk, // System clock
    input wire logic txd_out, // Device serial out or shift clock
    output logic line // Level driven onto the receive pin
);
    logic m0 = 1'b0, tx_q = 1'b1, abit = 1'b1;
    logic [7:0] sr = 8'hFF;
    assign line = m0 ? sr[0] : abit;
    // Clock slave: shifts after each rise
    always @(posedge pclk) begin
        tx_q <= txd_out;
        if (m0 && txd_out && !tx_q) begin
            sr <= {~sr[0], sr[7:1]};
        end
    end
    task automatic prime(input logic on, input logic [7:0] d);
        sr <= d;
        m0 <= on;
    endtask : prime
    // Frame: start, data LSB first, stop
    task automatic send(input logic [9:0] f, input int per);
        m0 <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            abit <= f[i];
            repeat (per - 1) @(posedge pclk);
        end
        @(posedge pclk);
        abit <= 1'b1;
    endtask : send
endmodule : spmb_far_end
`default_nettype wire

// *** test/spmb_serial_port_tb.sv ***
// Testbench: serial port modes and registers
`timescale 1ns/1ps
`default_nettype none
module spmb_serial_port_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic timer1_tick = 1'b0, timer3_tick = 1'b0;
    logic [31:0] q;
    logic e;
    int n_mismatch = 0, comparisons = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, rxd_out, rxd_oe, txd_out, far_line;
    wire logic rxd_line = rxd_oe ? rxd_out : far_line;
    spmb_serial_port #(.PORT_INDEX(0)) i_dut (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timer1_tick, .timer3_tick,
        .rxd_in(rxd_line), .rxd_out, .rxd_oe, .txd_out);
    spmb_far_end i_far (.pclk, .txd_out, .line(far_line));
    always #5 pclk = ~pclk;
    always @(posedge pclk) timer1_tick <= ~timer1_tick;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_flag(input int b);
        repeat (300) begin
            apb(1'b0, spmb_pkg::OFF_CTRL, 32'h0);
            if (q[b] === 1'b1) break;
        end
    endtask : wait_flag
    task automatic t_regs();
        apb(1'b0, spmb_pkg::OFF_T3CTL, 32'h0);
        chk(q[7:0], 8'h00);
        apb(1'b1, spmb_pkg::OFF_T3CTL, 32'h20);
        apb(1'b0, spmb_pkg::OFF_T3CTL, 32'h0);
        chk(q[7:0], 8'h20);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, spmb_pkg::OFF_T3CTL, 32'h0);
    endtask : t_regs
    task automatic t_m0_tx();
        logic [7:0] got;
        logic p = 1'b1;
        int i = 0;
        apb(1'b1, spmb_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, spmb_pkg::OFF_BUF, 32'hA5);
        while (i < 8) begin
            @(posedge pclk);
            if (txd_out && !p) begin
                got[i] = rxd_out;
                i++;
            end
            p = txd_out;
        end
        chk(got, 8'hA5);
        wait_flag(1);
        chk(q[1], 1'b1);
        chk(rxd_oe, 1'b0);
    endtask : t_m0_tx
    task automatic t_m0_rx();
        i_far.prime(1'b1, 8'h3C);
        apb(1'b1, spmb_pkg::OFF_CTRL, 32'h10);
        wait_flag(0);
        chk(q[0], 1'b1);
        apb(1'b0, spmb_pkg::OFF_BUF, 32'h0);
        chk(q[7:0], 8'h3C);
        i_far.prime(1'b0, 8'hFF);
    endtask : t_m0_rx
    task automatic t_m2_tx();
        logic [10:0] got;
        apb(1'b1, spmb_pkg::OFF_PWR, 32'h80);
        apb(1'b1, spmb_pkg::OFF_CTRL, 32'h88);
        apb(1'b1, spmb_pkg::OFF_BUF, 32'h5A);
        repeat (15) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            got[i] = txd_out;
            repeat (32) @(posedge pclk);
        end
        chk(got, {2'b11, 8'h5A, 1'b0});
        wait_flag(1);
        chk(q[1], 1'b1);
    endtask : t_m2_tx
    task automatic t_m1_rx();
        apb(1'b1, spmb_pkg::OFF_CTRL, 32'h50);
        i_far.send({1'b1, 8'hC3, 1'b0}, 32);
        repeat (40) @(posedge pclk);
        apb(1'b0, spmb_pkg::OFF_CTRL, 32'h0);
        chk(q[2:0], 3'b101);
        apb(1'b0, spmb_pkg::OFF_BUF, 32'h0);
        chk(q[7:0], 8'hC3);
        i_far.send({1'b1, 8'h11, 1'b0}, 32);
        repeat (40) @(posedge pclk);
        apb(1'b0, spmb_pkg::OFF_BUF, 32'h0);
        chk(q[7:0], 8'hC3);
    endtask : t_m1_rx
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_m0_tx();
        t_m0_rx();
        t_m2_tx();
        t_m1_rx();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        wrap_up();
    end
endmodule : spmb_serial_port_tb
`default_nettype wire
